/* File: rtl/nvc_prog.sv */
// nonvolatile configuration programming block
//
// Contract
// R1: configuration cells live only at 0x73 and 0x74.
// R2: programming accepted only in forced normal mode with factory presets.
// R3: after reset, presets in cells force forced normal mode (forced_normal_config=1).
// R4: after factory restore, issue system reset then forced normal mode.
// R5: host writes 0x73, 0x74, then matching crc to 0x75.
// R6: valid crc at 75h starts cell write; bad crc abandons.
// R7: successful programming ends with a system reset.
// R8: cell contents unreadable while cells are written.
// R9: after programming completes, ordinary writes cannot overwrite cells.
// R10: status bit 0 is ready-to-program flag, preset 1.
// R11: host should program no more than 200 times.
// R12: 6-bit counter at status 7:2 counts programs and restores, saturating.
// R13: saturated counter never refuses programming.
// R14: status bit 1 set on corrected single-bit failure.
// R15: multi-bit failure prevents restart after programming.
// R16: host should check the corrected-error flag at end of production.
// R17: crc covers exactly the bytes written to 0x73 and 0x74.
// R18: crc polynomial x8+x5+x3+x2+x+1, result inverted.
// R19: crc 8 bits, poly 0x2f, init 0xff, xor 0xff, unreflected.
// R20: crc takes 0x73 byte first, then 0x74, msb first.
`default_nettype none
module nvc_prog (
   input  wire logic       CLK_SYS_IN,      // 10 mhz system clock
   input  wire logic       RST_IN,          // async reset, active high
   input  wire logic       REG_WR_IN,       // register write strobe
   input  wire logic       REG_RD_IN,       // register read strobe
   input  wire logic [6:0] REG_ADDR_IN,     // register address
   input  wire logic [7:0] REG_WDATA_IN,    // write data
   output logic      [7:0] REG_RDATA_OUT,   // read data, registered
   output logic            REG_RVALID_OUT,  // read data valid pulse
   input  wire logic       RESTORE_REQ_IN,  // factory restore request pulse
   input  wire logic       ECC_SINGLE_IN,   // cell check corrected one bit
   input  wire logic       ECC_MULTI_IN,    // cell check found several bits
   input  wire logic       CELL_DONE_IN,    // cell write finished pulse
   output logic            CELL_WRITE_OUT,  // cell write in progress
   output logic            SYS_RESET_OUT,   // system reset request
   output logic            FORCED_NORMAL_OUT, // forced normal mode
   output logic      [7:0] STARTUP_CFG_OUT, // active start-up config
   output logic      [7:0] DEVICE_CFG_OUT   // active device config
);
   nvc_pkg::nvc_state_type state_r;
   nvc_pkg::nvc_req_type   req;
   nvc_pkg::nvc_image_type cells_r;
   nvc_pkg::nvc_image_type stage_r;
   logic [7:0]  crc_confirm_r;
   logic [5:0]  wr_count_r;
   logic        ecc_flag_r;
   logic        ready_r;
   logic        multi_err_r;
   logic [7:0]  timer_r;
   logic [7:0]  crc_calc;
   logic        is_preset;
   logic        crc_write;
   logic        crc_ok;
   logic        write_done;
   logic        restore_go;

   assign req = '{wr: REG_WR_IN, rd: REG_RD_IN, addr: REG_ADDR_IN, wdata: REG_WDATA_IN};

   // crc over staged bytes, 0x73 first
   nvc_crc8 i_nvc_crc8 (
      .BYTE0_IN (stage_r.startup), // see R20
      .BYTE1_IN (stage_r.devcfg),  // see R17
      .CRC_OUT  (crc_calc)
   );

   // presets held in cells and forced normal bit set
   assign is_preset  = (cells_r.startup == nvc_pkg::STARTUP_PRESET) &&
                       (cells_r.devcfg == nvc_pkg::DEVCFG_PRESET);
   assign FORCED_NORMAL_OUT = cells_r.devcfg[nvc_pkg::FORCED_NORMAL_CONFIG_BIT]; // see R3
   assign crc_write  = req.wr && (req.addr == nvc_pkg::NV_CRC_CONFIRM_REGISTER_ADDR);
   assign crc_ok     = crc_write && (req.wdata == crc_calc) && ready_r &&
                       FORCED_NORMAL_OUT && (state_r == nvc_pkg::ST_IDLE); // see R2, R6, R13
   assign write_done = (state_r == nvc_pkg::ST_WRITE) &&
                       (CELL_DONE_IN || (timer_r == 8'h00));
   assign restore_go = RESTORE_REQ_IN && (state_r == nvc_pkg::ST_IDLE);

   // programming sequencer
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         state_r <= nvc_pkg::ST_IDLE;
         timer_r <= 8'h00;
      end else begin
         case (state_r)
            nvc_pkg::ST_IDLE: begin
               if (crc_ok) begin
                  state_r <= nvc_pkg::ST_WRITE; // see R6
                  timer_r <= 8'(nvc_pkg::NV_WRITE_CYCLES - 1);
               end else if (restore_go) begin
                  state_r <= nvc_pkg::ST_RESET; // see R4
                  timer_r <= 8'(nvc_pkg::RESET_PULSE_CYCLES - 1);
               end
            end
            nvc_pkg::ST_WRITE: begin
               if (write_done) begin
                  if (multi_err_r || ECC_MULTI_IN) begin
                     state_r <= nvc_pkg::ST_HALT; // see R15
                  end else begin
                     state_r <= nvc_pkg::ST_RESET; // see R7
                     timer_r <= 8'(nvc_pkg::RESET_PULSE_CYCLES - 1);
                  end
               end else begin
                  timer_r <= timer_r - 8'h01;
               end
            end
            nvc_pkg::ST_RESET: begin
               if (timer_r == 8'h00) begin
                  state_r <= nvc_pkg::ST_IDLE;
               end else begin
                  timer_r <= timer_r - 8'h01;
               end
            end
            nvc_pkg::ST_HALT: state_r <= nvc_pkg::ST_HALT;
            default: state_r <= nvc_pkg::ST_IDLE;
         endcase
      end
   end

   // cell contents, committed on finish or restore
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         cells_r <= '{startup: nvc_pkg::STARTUP_PRESET, devcfg: nvc_pkg::DEVCFG_PRESET};
      end else if (restore_go) begin
         cells_r <= '{startup: nvc_pkg::STARTUP_PRESET, devcfg: nvc_pkg::DEVCFG_PRESET};
      end else if (write_done) begin
         cells_r <= stage_r; // see R1
      end
   end

   // staging registers at 0x73 and 0x74
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         stage_r <= '{startup: nvc_pkg::STARTUP_PRESET, devcfg: nvc_pkg::DEVCFG_PRESET};
      end else if (restore_go) begin
         stage_r <= '{startup: nvc_pkg::STARTUP_PRESET, devcfg: nvc_pkg::DEVCFG_PRESET};
      end else if (req.wr && ready_r && (state_r == nvc_pkg::ST_IDLE)) begin
         if (req.addr == nvc_pkg::NV_STARTUP_CONTROL_ADDR) begin
            stage_r.startup <= req.wdata; // see R9
         end
         if (req.addr == nvc_pkg::NV_DEVICE_CONFIG_CONTROL_ADDR) begin
            stage_r.devcfg <= req.wdata; // see R9
         end
      end
   end

   // crc confirm register stores last written byte
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         crc_confirm_r <= 8'h00;
      end else if (crc_write) begin
         crc_confirm_r <= req.wdata;
      end
   end

   // ready flag tracks preset content
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ready_r <= 1'b1;
      end else if (restore_go) begin
         ready_r <= 1'b1;
      end else if (write_done) begin
         ready_r <= 1'b0; // see R9, R10
      end else if (state_r == nvc_pkg::ST_IDLE) begin
         ready_r <= ready_r & is_preset;
      end
   end

   // saturating write counter
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         wr_count_r <= 6'h00;
      end else if ((write_done || restore_go) && (wr_count_r != nvc_pkg::WRCNT_MAX)) begin
         wr_count_r <= wr_count_r + 6'h01; // see R12
      end
   end

   // ecc flags; set wins over a status write clearing it
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         ecc_flag_r  <= 1'b0;
         multi_err_r <= 1'b0;
      end else begin
         if (ECC_SINGLE_IN) begin
            ecc_flag_r <= 1'b1; // see R14
         end else if (req.wr && (req.addr == nvc_pkg::NV_PROGRAM_STATUS_ADDR) &&
                      !req.wdata[nvc_pkg::STAT_ECC_BIT]) begin
            ecc_flag_r <= 1'b0;
         end
         if (ECC_MULTI_IN) begin
            multi_err_r <= 1'b1; // see R15
         end
      end
   end

   // registered read port
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         REG_RDATA_OUT  <= 8'h00;
         REG_RVALID_OUT <= 1'b0;
      end else begin
         REG_RVALID_OUT <= req.rd;
         if (req.rd) begin
            case (req.addr)
               nvc_pkg::NV_PROGRAM_STATUS_ADDR:
                  REG_RDATA_OUT <= {wr_count_r, ecc_flag_r, ready_r}; // see R10, R12
               nvc_pkg::NV_STARTUP_CONTROL_ADDR:
                  REG_RDATA_OUT <= (state_r == nvc_pkg::ST_WRITE) ? 8'h00
                                   : stage_r.startup; // see R8
               nvc_pkg::NV_DEVICE_CONFIG_CONTROL_ADDR:
                  REG_RDATA_OUT <= (state_r == nvc_pkg::ST_WRITE) ? 8'h00
                                   : stage_r.devcfg; // see R8
               nvc_pkg::NV_CRC_CONFIRM_REGISTER_ADDR:
                  REG_RDATA_OUT <= crc_confirm_r;
               default:
                  REG_RDATA_OUT <= 8'h00;
            endcase
         end
      end
   end

   // outputs
   assign CELL_WRITE_OUT  = (state_r == nvc_pkg::ST_WRITE);
   assign SYS_RESET_OUT   = (state_r == nvc_pkg::ST_RESET); // see R4, R7
   assign STARTUP_CFG_OUT = cells_r.startup;
   assign DEVICE_CFG_OUT  = cells_r.devcfg;
endmodule
`default_nettype wire

/* File: rtl/nvc_pkg.sv */
// package: constants and types for the nonvolatile configuration programming block
`default_nettype none
package nvc_pkg;
   localparam logic [6:0] NV_PROGRAM_STATUS_ADDR        = 7'h70;
   localparam logic [6:0] NV_STARTUP_CONTROL_ADDR       = 7'h73;
   localparam logic [6:0] NV_DEVICE_CONFIG_CONTROL_ADDR = 7'h74;
   localparam logic [6:0] NV_CRC_CONFIRM_REGISTER_ADDR  = 7'h75;
   // field positions of the status register
   localparam int STAT_READY_BIT = 0;
   localparam int STAT_ECC_BIT   = 1;
   localparam int STAT_CNT_LSB   = 2;
   // factory presets and reset values
   localparam logic [7:0] STARTUP_PRESET = 8'h00;
   localparam logic [7:0] DEVCFG_PRESET  = 8'h08;
   localparam int         FORCED_NORMAL_CONFIG_BIT       = 3;
   localparam logic [5:0] WRCNT_MAX      = 6'h3f;
   localparam logic [7:0] CRC_POLY       = 8'h2f;
   localparam logic [7:0] CRC_INIT       = 8'hff;
   localparam logic [7:0] CRC_XOR        = 8'hff;
   // cell write time
   localparam int NV_WRITE_TIME_US   = 10;
   localparam int CLK_MHZ            = 10;
   localparam int NV_WRITE_CYCLES    = NV_WRITE_TIME_US * CLK_MHZ;
   localparam int RESET_PULSE_CYCLES = 4;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_WRITE = 2'b01,
      ST_RESET = 2'b10,
      ST_HALT  = 2'b11
   } nvc_state_type;

   // register bus access
   typedef struct packed {
      logic       wr;
      logic       rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } nvc_req_type;

   // cell image: start-up and device config bytes
   typedef struct packed {
      logic [7:0] startup;
      logic [7:0] devcfg;
   } nvc_image_type;
endpackage
`default_nettype wire

/* File: rtl/nvc_crc8.sv */
// combinational crc-8 over two bytes, msb first
`default_nettype none
module nvc_crc8 (
   input  wire logic [7:0] BYTE0_IN, // first byte
   input  wire logic [7:0] BYTE1_IN, // second byte
   output logic      [7:0] CRC_OUT   // inverted crc
);
   logic [15:0] stream;
   logic [7:0]  acc;
   assign stream = {BYTE0_IN, BYTE1_IN};
   // bitwise long division, no reflection
   always_comb begin
      acc = nvc_pkg::CRC_INIT;
      for (int i = 15; i >= 0; i--) begin
         if (acc[7] ^ stream[i]) begin
            acc = {acc[6:0], 1'b0} ^ nvc_pkg::CRC_POLY; // see R18, R19
         end else begin
            acc = {acc[6:0], 1'b0};
         end
      end
      CRC_OUT = acc ^ nvc_pkg::CRC_XOR; // see R18
   end
endmodule
`default_nettype wire

/* File: test/nvc_cell_model.sv */
// cell array model: ends writes and injects multi-bit failures on command
`default_nettype none
module nvc_cell_model #(
   parameter int DONE_DELAY = 20 // cycles of cell write before done
) (
   input  wire logic CLK_IN,              // system clock
   input  wire logic CELL_WRITE_IN,       // cell write in progress
   input  wire logic MULTI_FAIL_IN,       // inject a multi-bit failure
   output var  logic CELL_DONE_OUT = 1'b0, // write finished pulse
   output var  logic ECC_MULTI_OUT = 1'b0  // multi-bit failure pulse
);
   timeunit 1ns;
   timeprecision 1ns;
   int cnt = 0;
   // count write cycles, answer off the sampling edge
   always @(negedge CLK_IN) begin
      cnt <= CELL_WRITE_IN ? cnt + 1 : 0;
      CELL_DONE_OUT <= CELL_WRITE_IN && cnt == DONE_DELAY;
      ECC_MULTI_OUT <= CELL_WRITE_IN && MULTI_FAIL_IN && cnt == 1;
   end
endmodule
`default_nettype wire

/* File: test/nvc_prog_sva.sv */
// assertion checker for the nonvolatile configuration programming block
`default_nettype none
module nvc_prog_sva (
   input wire logic       CLK_SYS_IN, RST_IN, REG_WR_IN, REG_RD_IN, RESTORE_REQ_IN,
   input wire logic [6:0] REG_ADDR_IN,
   input wire logic [7:0] REG_RDATA_OUT, STARTUP_CFG_OUT, DEVICE_CFG_OUT,
   input wire logic       REG_RVALID_OUT, CELL_WRITE_OUT, SYS_RESET_OUT, FORCED_NORMAL_OUT
);
   timeunit 1ns;
   timeprecision 1ns;
   logic crc_wr_r;
   // crc confirm write seen last cycle
   always_ff @(posedge CLK_SYS_IN or posedge RST_IN) begin
      if (RST_IN) begin
         crc_wr_r <= 1'b0;
      end else begin
         crc_wr_r <= REG_WR_IN && REG_ADDR_IN == nvc_pkg::NV_CRC_CONFIRM_REGISTER_ADDR;
      end
   end
   default clocking @(posedge CLK_SYS_IN); endclocking
   default disable iff (RST_IN);
   // bus answers, cell writes, system resets and forced normal mode
   a_rvalid_follows_rd: assert property (REG_RVALID_OUT == $past(REG_RD_IN))
      else $error("read valid not one cycle after read");
   a_write_from_crc: assert property ($rose(CELL_WRITE_OUT) |-> crc_wr_r)
      else $error("cell write started without crc write");
   a_write_bounded: assert property ($rose(CELL_WRITE_OUT) |-> ##[1:100] !CELL_WRITE_OUT)
      else $error("cell write too long");
   a_read_blanked: assert property (CELL_WRITE_OUT && REG_RD_IN &&
      (REG_ADDR_IN == nvc_pkg::NV_STARTUP_CONTROL_ADDR ||
       REG_ADDR_IN == nvc_pkg::NV_DEVICE_CONFIG_CONTROL_ADDR) |=> REG_RDATA_OUT == 8'h00)
      else $error("cells readable during write");
   a_reset_pulse_len: assert property ($rose(SYS_RESET_OUT) |-> SYS_RESET_OUT [*4] ##1 !SYS_RESET_OUT)
      else $error("system reset pulse length wrong");
   a_restore_reset: assert property (RESTORE_REQ_IN && !CELL_WRITE_OUT && !SYS_RESET_OUT |=> SYS_RESET_OUT)
      else $error("restore without system reset");
   a_forced_preset: assert property (STARTUP_CFG_OUT == nvc_pkg::STARTUP_PRESET &&
      DEVICE_CFG_OUT == nvc_pkg::DEVCFG_PRESET |-> FORCED_NORMAL_OUT)
      else $error("preset cells without forced normal mode");
   a_cells_locked: assert property ($changed(STARTUP_CFG_OUT) || $changed(DEVICE_CFG_OUT) |-> SYS_RESET_OUT || $past(CELL_WRITE_OUT))
      else $error("cells changed outside programming");
   c_cell_write: cover property ($rose(CELL_WRITE_OUT));
   c_restore: cover property (RESTORE_REQ_IN ##1 SYS_RESET_OUT);
   c_read_in_write: cover property (CELL_WRITE_OUT && REG_RD_IN);
endmodule
bind nvc_prog nvc_prog_sva i_nvc_prog_sva (.CLK_SYS_IN, .RST_IN, .REG_WR_IN, .REG_RD_IN,
   .RESTORE_REQ_IN, .REG_ADDR_IN, .REG_RDATA_OUT, .STARTUP_CFG_OUT, .DEVICE_CFG_OUT,
   .REG_RVALID_OUT, .CELL_WRITE_OUT, .SYS_RESET_OUT, .FORCED_NORMAL_OUT);
`default_nettype wire

/* File: test/nvc_prog_test.sv */
// self-checking testbench for the nonvolatile configuration programming block
`default_nettype none
module nvc_prog_test;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [6:0] ST = nvc_pkg::NV_PROGRAM_STATUS_ADDR;
   logic clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, rq = 1'b0, ecc_s = 1'b0, fail_m = 1'b0;
   logic [6:0] addr = 7'h00;
   logic [7:0] wd = 8'h00;
   wire logic [7:0] rdat, scfg, dcfg;
   wire logic       rv, done, ecc_m, cw, sr, fn;
   int n_fail = 0;
   int n_compared = 0;
   nvc_prog i_nvc_prog (.CLK_SYS_IN(clk), .RST_IN(rst), .REG_WR_IN(wr), .REG_RD_IN(rd),
      .REG_ADDR_IN(addr), .REG_WDATA_IN(wd), .REG_RDATA_OUT(rdat), .REG_RVALID_OUT(rv),
      .RESTORE_REQ_IN(rq), .ECC_SINGLE_IN(ecc_s), .ECC_MULTI_IN(ecc_m), .CELL_DONE_IN(done),
      .CELL_WRITE_OUT(cw), .SYS_RESET_OUT(sr), .FORCED_NORMAL_OUT(fn),
      .STARTUP_CFG_OUT(scfg), .DEVICE_CFG_OUT(dcfg));
   nvc_cell_model i_nvc_cell_model (.CLK_IN(clk), .CELL_WRITE_IN(cw), .MULTI_FAIL_IN(fail_m),
      .CELL_DONE_OUT(done), .ECC_MULTI_OUT(ecc_m));
   // compare, report and count
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_fail++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // crc-8 poly 2f, init ff, inverted, first byte msb first
   function automatic logic [7:0] crc8(input logic [7:0] b0, input logic [7:0] b1);
      logic [7:0]  c;
      logic [15:0] d;
      c = 8'hff;
      d = {b0, b1};
      for (int i = 15; i >= 0; i--) begin
         c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ 8'h2f) : {c[6:0], 1'b0};
      end
      return ~c;
   endfunction
   task automatic wr_reg(input logic [6:0] a, input logic [7:0] d);
      @(negedge clk);
      wr = 1'b1;
      addr = a;
      wd = d;
      @(negedge clk);
      wr = 1'b0;
   endtask
   task automatic rd_reg(input logic [6:0] a, input logic [7:0] exp);
      @(negedge clk);
      rd = 1'b1;
      addr = a;
      @(negedge clk);
      rd = 1'b0;
      chk({7'h00, rv}, 8'h01);
      chk(rdat, exp);
   endtask
   // stage both bytes then confirm, crc optionally spoilt; called rarely
   task automatic prog(input logic [7:0] s, input logic [7:0] d, input logic [7:0] flip);
      wr_reg(nvc_pkg::NV_STARTUP_CONTROL_ADDR, s);
      wr_reg(nvc_pkg::NV_DEVICE_CONFIG_CONTROL_ADDR, d);
      wr_reg(nvc_pkg::NV_CRC_CONFIRM_REGISTER_ADDR, crc8(s, d) ^ flip);
   endtask
   // wait a bounded time for system reset, then check its four cycles
   task automatic sr_cycle(input int lim);
      int k;
      k = 0;
      while (sr !== 1'b1 && k < lim) begin
         @(negedge clk);
         k++;
      end
      chk({7'h00, sr}, 8'h01);
      repeat (4) @(negedge clk);
      chk({7'h00, sr}, 8'h00);
   endtask
   task automatic restore();
      @(negedge clk);
      rq = 1'b1;
      @(negedge clk);
      rq = 1'b0;
      sr_cycle(0);
      chk(dcfg, 8'h08);
   endtask
   task automatic end_sim();
      $display("compared %0d failed %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   initial begin
      forever #50 clk = ~clk;
   end
   // watchdog far beyond the expected run
   initial begin
      #3000000;
      n_fail++;
      end_sim();
   end
   // main sequence
   initial begin
      repeat (4) @(negedge clk);
      rst = 1'b0;
      rd_reg(ST, 8'h01);
      chk({7'h00, fn}, 8'h01);
      prog(8'h5a, 8'h34, 8'h01);
      chk({7'h00, cw}, 8'h00);
      prog(8'h5a, 8'h34, 8'h00);
      chk({7'h00, cw}, 8'h01);
      rd_reg(nvc_pkg::NV_STARTUP_CONTROL_ADDR, 8'h00);
      sr_cycle(200);
      chk(scfg, 8'h5a);
      chk(dcfg, 8'h34);
      chk({7'h00, fn}, 8'h00);
      rd_reg(ST, 8'h04);
      prog(8'hff, 8'h34, 8'h00);
      chk({7'h00, cw}, 8'h00);
      chk(scfg, 8'h5a);
      rd_reg(nvc_pkg::NV_STARTUP_CONTROL_ADDR, 8'h5a);
      for (int i = 2; i <= 64; i++) begin
         restore();
         rd_reg(ST, {(i > 63 ? 6'h3f : 6'(i)), 2'b01});
      end
      prog(8'h12, 8'h08, 8'h00);
      chk({7'h00, cw}, 8'h01);
      sr_cycle(200);
      rd_reg(ST, 8'hfc);
      restore();
      @(negedge clk);
      ecc_s = 1'b1;
      @(negedge clk);
      ecc_s = 1'b0;
      rd_reg(ST, 8'hff);
      wr_reg(ST, 8'h00);
      rd_reg(ST, 8'hfd);
      fail_m = 1'b1;
      prog(8'h12, 8'h08, 8'h00);
      repeat (150) begin
         @(negedge clk);
         chk({7'h00, sr}, 8'h00);
      end
      end_sim();
   end
endmodule
`default_nettype wire
